// *** verification/spfc_host_model.sv ***
/*
 * Behavioural PMBus host: hands the configuration block one decoded
 * command per call and collects the answer.
 * Assumes the block samples commands on the rising edge of clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module spfc_host_model (
    input wire logic clk_sys,
    input wire logic cmdAck,
    input wire logic [15:0] rdData,
    input wire logic [1:0] rdByteCount,
    output logic cmdStrobe,
    output logic cmdWrite,
    output logic [7:0] cmdCode,
    output logic [1:0] cmdByteCount,
    output logic [15:0] cmdWriteData
);
    // Quiet bus from time zero
    initial
    begin
        cmdStrobe = 1'b0;
        cmdWrite = 1'b0;
        cmdCode = 8'h00;
        cmdByteCount = 2'h0;
        cmdWriteData = 16'h0000;
    end

    // Well-formed length: one byte, or the whole linear word at once
    function automatic logic [1:0] len_of(input logic [7:0] code);
        return (code == spfc_pkg::CMD_PHASE_RANGE) ? spfc_pkg::LEN_PHASE_RANGE
            : spfc_pkg::LEN_FREQ_SELECT;
    endfunction : len_of

    // One transfer; data is inverted after, so no stale copy looks valid
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [1:0] cnt,
        input logic [15:0] data, output logic ack, output logic [15:0] rd,
        output logic [1:0] rc);
        @(negedge clk_sys);
        cmdStrobe = 1'b1;
        cmdWrite = wr;
        cmdCode = code;
        cmdByteCount = cnt;
        cmdWriteData = data;
        @(negedge clk_sys);
        cmdStrobe = 1'b0;
        cmdWriteData = ~data;
        ack = cmdAck;
        rd = rdData;
        rc = rdByteCount;
    endtask : xfer
endmodule : spfc_host_model
`default_nettype wire

// *** verification/testbench.sv ***
/*
 * Self-checking bench for the phase, range and frequency configuration.
 * Assumes the host model in its own file and a shortened relock count.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [7:0] code; logic [15:0] data;
        logic [9:0] expA; logic [9:0] expB;} spfc_row_t;
    logic clk_sys, rst_n, clearFaults, runPin0, runPin1, opOn0, opOn1;
    logic vinAboveOn, vinBelowOff, maskPllUnlock, cmdStrobe, cmdWrite, cmdAck;
    logic busyFault, cmlFault, pllUnlock, shareClkShare, extOscSel, shareClkOut, shareClkOe;
    logic [7:0] cmdCode;
    logic [1:0] cmdByteCount, rdByteCount, rc;
    logic [15:0] cmdWriteData, rdData, rd, expRd;
    logic [8:0] phase0Deg, phase1Deg;
    logic [12:0] voutMax0Mv, voutMax1Mv;
    logic [9:0] freqKhz;
    logic ack;
    int failures, checkCount;
    spfc_row_t rows [16];

    spfc_host_model host (.clk_sys(clk_sys), .cmdAck(cmdAck), .rdData(rdData),
        .rdByteCount(rdByteCount), .cmdStrobe(cmdStrobe), .cmdWrite(cmdWrite),
        .cmdCode(cmdCode), .cmdByteCount(cmdByteCount), .cmdWriteData(cmdWriteData));

    spfc_config #(.RELOCK_CYCLES(8)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmdStrobe(cmdStrobe), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
        .cmdByteCount(cmdByteCount), .cmdWriteData(cmdWriteData), .clearFaults(clearFaults),
        .runPin0(runPin0), .runPin1(runPin1), .opOn0(opOn0), .opOn1(opOn1),
        .vinAboveOn(vinAboveOn), .vinBelowOff(vinBelowOff), .maskPllUnlock(maskPllUnlock),
        .cmdAck(cmdAck), .rdData(rdData), .rdByteCount(rdByteCount), .busyFault(busyFault),
        .cmlFault(cmlFault), .pllUnlock(pllUnlock), .phase0Deg(phase0Deg),
        .phase1Deg(phase1Deg), .voutMax0Mv(voutMax0Mv), .voutMax1Mv(voutMax1Mv),
        .shareClkShare(shareClkShare), .freqKhz(freqKhz), .extOscSel(extOscSel),
        .shareClkOut(shareClkOut), .shareClkOe(shareClkOe));

    // 10 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_bit(input logic got, input logic exp);
        check_val({15'h0000, got}, {15'h0000, exp});
    endtask : check_bit

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        host.xfer(1'b1, code, host.len_of(code), data, ack, rd, rc);
    endtask : wr

    task automatic rdc(input logic [7:0] code);
        host.xfer(1'b0, code, host.len_of(code), 16'h0000, ack, rd, rc);
    endtask : rdc

    task automatic pulse_clear();
        @(negedge clk_sys);
        clearFaults = 1'b1;
        @(negedge clk_sys);
        clearFaults = 1'b0;
    endtask : pulse_clear

    task print_verdict();
        $display("checks %0d mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    // Watchdog: the whole sequence needs well under 1500 cycles
    initial
    begin
        #(3000 * 100);
        failures++;
        print_verdict();
    end

    initial
    begin
        rows = '{'{8'hf5, 16'h0000, 10'h000, 10'h0b4}, '{8'hf5, 16'h0071, 10'h05a, 10'h10e},
            '{8'hf5, 16'h0042, 10'h000, 10'h0f0}, '{8'hf5, 16'h0023, 10'h000, 10'h078},
            '{8'hf5, 16'h0014, 10'h078, 10'h0f0}, '{8'hf5, 16'h0065, 10'h03c, 10'h0f0},
            '{8'hf5, 16'h0016, 10'h078, 10'h12c}, '{8'h33, 16'hf3e8, 10'h0fa, 10'h000},
            '{8'h33, 16'hfabc, 10'h15e, 10'h000}, '{8'h33, 16'hfb52, 10'h1a9, 10'h000},
            '{8'h33, 16'hfbe8, 10'h1f4, 10'h000}, '{8'h33, 16'h023f, 10'h23f, 10'h000},
            '{8'h33, 16'h028a, 10'h28a, 10'h000}, '{8'h33, 16'h02ee, 10'h2ee, 10'h000},
            '{8'h33, 16'h03e8, 10'h3e8, 10'h000}, '{8'h33, 16'h0000, 10'h000, 10'h001}};
        {rst_n, clearFaults, runPin0, runPin1, opOn0, opOn1} = 6'h00;
        {vinAboveOn, vinBelowOff, maskPllUnlock} = 3'h2;
        failures = 0;
        checkCount = 0;
        repeat (10) @(negedge clk_sys);
        check_val(16'(phase1Deg), 16'h00b4);
        check_val(16'(voutMax1Mv), 16'h157c);
        check_val(16'(freqKhz), 16'h015e);
        check_bit(shareClkOe, 1'b1);
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        rdc(8'hf5);
        check_val(rd, 16'h0010);
        rdc(8'h33);
        check_val(rd, 16'hfabc);
        // Share clock pin against the input voltage comparators
        {vinAboveOn, vinBelowOff} = 2'h2;
        repeat (5) @(negedge clk_sys);
        check_bit(shareClkOe, 1'b0);
        {vinAboveOn, vinBelowOff} = 2'h1;
        repeat (5) @(negedge clk_sys);
        check_bit(shareClkOe, 1'b1);
        check_bit(shareClkOut, 1'b0);
        {vinAboveOn, vinBelowOff} = 2'h2;
        wr(8'hf5, 16'h0000);
        {vinAboveOn, vinBelowOff} = 2'h1;
        repeat (5) @(negedge clk_sys);
        check_bit(shareClkOe, 1'b0);
        {vinAboveOn, vinBelowOff} = 2'h2;
        // Table of phase/range bytes and frequency codes, all while off
        foreach (rows[i])
        begin
            wr(rows[i].code, rows[i].data);
            check_bit(ack, 1'b1);
            rdc(rows[i].code);
            expRd = rows[i].code == 8'hf5 ? {8'h00, rows[i].data[7:0]} : rows[i].data;
            check_val(rd, expRd);
            check_val(16'(rc), 16'(host.len_of(rows[i].code)));
            check_bit(busyFault | cmlFault, 1'b0);
            if (rows[i].code == 8'hf5)
            begin
                check_val(16'(phase0Deg), 16'(rows[i].expA));
                check_val(16'(phase1Deg), 16'(rows[i].expB));
                check_val(16'(voutMax0Mv), rows[i].data[6] ? 16'h0abe : 16'h1000);
                check_val(16'(voutMax1Mv), rows[i].data[5] ? 16'h0abe : 16'h157c);
                check_bit(shareClkShare, rows[i].data[4]);
            end
            else
            begin
                check_val(16'(freqKhz), 16'(rows[i].expA));
                check_bit(extOscSel, rows[i].expB[0]);
            end
        end
        // Relock window after a change, then a second change to another code, masked
        repeat (12) @(negedge clk_sys);
        wr(8'h33, 16'hf3e8);
        @(negedge clk_sys);
        check_bit(pllUnlock, 1'b1);
        repeat (7) @(negedge clk_sys);
        check_bit(pllUnlock, 1'b1);
        @(negedge clk_sys);
        check_bit(pllUnlock, 1'b0);
        maskPllUnlock = 1'b1;
        wr(8'h33, 16'hfabc);
        @(negedge clk_sys);
        check_bit(pllUnlock, 1'b0);
        repeat (10) @(negedge clk_sys);
        maskPllUnlock = 1'b0;
        // Running channel refuses writes; a commanded-off channel does not
        {runPin0, opOn0} = 2'h3;
        repeat (4) @(negedge clk_sys);
        wr(8'hf5, 16'h0003);
        check_bit(busyFault, 1'b1);
        rdc(8'hf5);
        check_val(rd, 16'h0016);
        pulse_clear();
        check_bit(busyFault, 1'b0);
        {opOn0, runPin1} = 2'h1;
        repeat (4) @(negedge clk_sys);
        wr(8'hf5, 16'h0003);
        rdc(8'hf5);
        check_val(rd, 16'h0003);
        check_bit(busyFault, 1'b0);
        opOn1 = 1'b1;
        repeat (4) @(negedge clk_sys);
        wr(8'h33, 16'h03e8);
        check_bit(busyFault, 1'b1);
        rdc(8'h33);
        check_val(rd, 16'hfabc);
        check_val(16'(freqKhz), 16'h015e);
        {runPin0, runPin1, opOn1} = 3'h0;
        pulse_clear();
        // Malformed requests: reserved phase code, wrong lengths, unknown code
        wr(8'hf5, 16'h0007);
        check_bit(cmlFault, 1'b1);
        rdc(8'hf5);
        check_val(rd, 16'h0003);
        pulse_clear();
        host.xfer(1'b1, 8'h33, 2'h1, 16'h03e8, ack, rd, rc);
        check_bit(cmlFault, 1'b1);
        host.xfer(1'b0, 8'hf5, 2'h2, 16'h0000, ack, rd, rc);
        check_val(rd, 16'h0000);
        host.xfer(1'b0, 8'h01, 2'h1, 16'h0000, ack, rd, rc);
        check_val({ack, rc, rd[12:0]}, 16'h8000);
        // Reset in mid-run restores the stored defaults
        rst_n = 1'b0;
        @(negedge clk_sys);
        check_val(16'(phase1Deg), 16'h00b4);
        check_bit(cmlFault, 1'b0);
        rst_n = 1'b1;
        rdc(8'hf5);
        check_val(rd, 16'h0010);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire

// *** verilog/spfc_config.sv ***
/*
 * Phase, range and switching frequency configuration for a dual step-down
 * controller, written and read as decoded PMBus commands.
 * Assumes a PMBus front end that hands over one decoded command per
 * cmdStrobe pulse on clk_sys; run pins and input voltage comparators are
 * asynchronous and are synchronised here.
 */
// Notes on behaviour
// [RULE1] Configuration writes are processed only while both channels are off by pin or command.
// [RULE2] A configuration write while running is dropped, the old value kept and busy flagged.
// [RULE3] Bits 2:0 choose the phase pair 0/180, 90/270, 0/240, 0/120, 120/240, 60/240, 120/300.
// [RULE4] Bit 6 set limits channel 0 to 2.75 V, clear allows 4.096 V.
// [RULE5] Bit 5 set limits channel 1 to 2.75 V, clear allows 5.5 V.
// [RULE6] Bit 4 set holds the shared clock low until input is above turn-on and below turn-off.
// [RULE7] Bit 4 clear pulls the shared clock low only before input first reaches turn-on.
// [RULE8] The frequency selector maps its nine codes to external clock or 250 to 1000 kHz.
// [RULE9] The frequency selector is a two-byte linear value, 5-bit exponent and 11-bit mantissa.
// [RULE10] The phase/range command carries exactly one data byte on read and write.
// [RULE11] A frequency change while off may show PLL unlock while the PLL relocks.
// [RULE12] The unlock mask suppresses the PLL unlock report.
// [RULE13] Reads return the last accepted value; rejected writes change nothing.
`timescale 1ns/1ps
`default_nettype none
module spfc_config #(
    parameter int RELOCK_CYCLES = spfc_pkg::PLL_RELOCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmdStrobe,
    input wire logic cmdWrite,
    input wire logic [7:0] cmdCode,
    input wire logic [1:0] cmdByteCount,
    input wire logic [15:0] cmdWriteData,
    input wire logic clearFaults,
    input wire logic runPin0,
    input wire logic runPin1,
    input wire logic opOn0,
    input wire logic opOn1,
    input wire logic vinAboveOn,
    input wire logic vinBelowOff,
    input wire logic maskPllUnlock,
    output logic cmdAck,
    output logic [15:0] rdData,
    output logic [1:0] rdByteCount,
    output logic busyFault,
    output logic cmlFault,
    output logic pllUnlock,
    output logic [8:0] phase0Deg,
    output logic [8:0] phase1Deg,
    output logic [12:0] voutMax0Mv,
    output logic [12:0] voutMax1Mv,
    output logic shareClkShare,
    output logic [9:0] freqKhz,
    output logic extOscSel,
    output logic shareClkOut,
    output logic shareClkOe
);
    // Every check in this module runs on the system clock and sleeps through reset
    default clocking cbSys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Frequency decode: {supported, external, kHz}
    function automatic logic [11:0] decodeFreq(input logic [15:0] code);
        case (code)
            spfc_pkg::FSEL_EXT: decodeFreq = {2'b11, 10'd0};
            spfc_pkg::FSEL_250: decodeFreq = {2'b10, 10'd250};
            spfc_pkg::FSEL_350: decodeFreq = {2'b10, 10'd350};
            spfc_pkg::FSEL_425: decodeFreq = {2'b10, 10'd425};
            spfc_pkg::FSEL_500: decodeFreq = {2'b10, 10'd500};
            spfc_pkg::FSEL_575: decodeFreq = {2'b10, 10'd575};
            spfc_pkg::FSEL_650: decodeFreq = {2'b10, 10'd650};
            spfc_pkg::FSEL_750: decodeFreq = {2'b10, 10'd750};
            spfc_pkg::FSEL_1000: decodeFreq = {2'b10, 10'd1000};
            default: decodeFreq = 12'h000;
        endcase
    endfunction : decodeFreq

    logic [1:0] runMeta, runSync, vinMeta, vinSync;
    logic [7:0] phaseRange;
    logic [15:0] freqSelect;
    logic running, isPhase, isFreq, lenOk, valueOk, accept, reject, freqStart;
    logic relockBusy, vinLow, powerSeen;
    logic [11:0] freqDec, storedDec;

    // Two flops on the pins; only the second stage is read
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            runMeta <= 2'h0;
            runSync <= 2'h0;
            vinMeta <= 2'h0;
            vinSync <= 2'h0;
        end
        else
        begin
            runMeta <= {runPin1, runPin0};
            runSync <= runMeta;
            vinMeta <= {vinBelowOff, vinAboveOn};
            vinSync <= vinMeta;
        end
    end

    // Off means every channel has its pin low or is commanded off
    assign running = (runSync[0] & opOn0) | (runSync[1] & opOn1); // see [RULE1]
    assign isPhase = (cmdCode == spfc_pkg::CMD_PHASE_RANGE);
    assign isFreq = (cmdCode == spfc_pkg::CMD_FREQ_SELECT);
    assign lenOk = isPhase ? (cmdByteCount == spfc_pkg::LEN_PHASE_RANGE) // see [RULE10]
                           : (cmdByteCount == spfc_pkg::LEN_FREQ_SELECT); // see [RULE9]
    assign freqDec = decodeFreq(cmdWriteData);
    // Decode of the stored selector, kept as a net so its fields can be sliced
    assign storedDec = decodeFreq(freqSelect);
    // Phase code 111 has no defined pair, so it is refused like a bad frequency
    assign valueOk = isPhase ? (cmdWriteData[spfc_pkg::PHASE_MSB:0] != 3'h7) : freqDec[11];
    assign accept = cmdStrobe & cmdWrite & (isPhase | isFreq) & lenOk & valueOk & !running;
    assign reject = cmdStrobe & cmdWrite & (isPhase | isFreq) & lenOk & valueOk & running;
    assign freqStart = accept & isFreq & (cmdWriteData != freqSelect);

    // Stored values move only on an accepted write
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phaseRange <= spfc_pkg::PHASE_RANGE_RESET;
            freqSelect <= spfc_pkg::FREQ_SELECT_RESET;
        end
        else if (accept)
        begin
            if (isPhase)
                phaseRange <= cmdWriteData[7:0]; // see [RULE13]
            else
                freqSelect <= cmdWriteData; // see [RULE13]
        end
    end

    // Fault flags: a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busyFault <= 1'b0;
            cmlFault <= 1'b0;
        end
        else
        begin
            busyFault <= reject | (busyFault & !clearFaults); // see [RULE2]
            cmlFault <= (cmdStrobe & (isPhase | isFreq) & (cmdWrite ? !(lenOk & valueOk)
                        : !lenOk)) | (cmlFault & !clearFaults);
        end
    end

    // Command answer, one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmdAck <= 1'b0;
            rdData <= 16'h0;
            rdByteCount <= 2'h0;
        end
        else
        begin
            cmdAck <= cmdStrobe;
            if (cmdStrobe & !cmdWrite & isPhase & lenOk)
            begin
                rdData <= {8'h0, phaseRange}; // see [RULE10]
                rdByteCount <= spfc_pkg::LEN_PHASE_RANGE;
            end
            else if (cmdStrobe & !cmdWrite & isFreq & lenOk)
            begin
                rdData <= freqSelect; // see [RULE9]
                rdByteCount <= spfc_pkg::LEN_FREQ_SELECT;
            end
            else if (cmdStrobe)
            begin
                rdData <= 16'h0;
                rdByteCount <= 2'h0;
            end
        end
    end

    // Decoded controls toward the PWM engine
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase0Deg <= 9'd0;
            phase1Deg <= 9'd180;
            voutMax0Mv <= spfc_pkg::VMAX_CH0_MV;
            voutMax1Mv <= spfc_pkg::VMAX_CH1_MV;
            shareClkShare <= 1'b1;
            freqKhz <= 10'd350;
            extOscSel <= 1'b0;
        end
        else
        begin
            case (phaseRange[spfc_pkg::PHASE_MSB:0]) // see [RULE3]
                spfc_pkg::PH_0_180: {phase0Deg, phase1Deg} <= {9'd0, 9'd180};
                spfc_pkg::PH_90_270: {phase0Deg, phase1Deg} <= {9'd90, 9'd270};
                spfc_pkg::PH_0_240: {phase0Deg, phase1Deg} <= {9'd0, 9'd240};
                spfc_pkg::PH_0_120: {phase0Deg, phase1Deg} <= {9'd0, 9'd120};
                spfc_pkg::PH_120_240: {phase0Deg, phase1Deg} <= {9'd120, 9'd240};
                spfc_pkg::PH_60_240: {phase0Deg, phase1Deg} <= {9'd60, 9'd240};
                spfc_pkg::PH_120_300: {phase0Deg, phase1Deg} <= {9'd120, 9'd300};
                default: {phase0Deg, phase1Deg} <= {9'd0, 9'd180};
            endcase
            voutMax0Mv <= phaseRange[spfc_pkg::BIT_RANGE0] ? spfc_pkg::VMAX_LOW_RANGE_MV
                                                           : spfc_pkg::VMAX_CH0_MV; // see [RULE4]
            voutMax1Mv <= phaseRange[spfc_pkg::BIT_RANGE1] ? spfc_pkg::VMAX_LOW_RANGE_MV
                                                           : spfc_pkg::VMAX_CH1_MV; // see [RULE5]
            shareClkShare <= phaseRange[spfc_pkg::BIT_SHARE_CLK];
            freqKhz <= storedDec[9:0]; // see [RULE8]
            extOscSel <= storedDec[10]; // see [RULE8]
        end
    end

    // Input supply state with hysteresis, and first power-up seen
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vinLow <= 1'b1;
            powerSeen <= 1'b0;
        end
        else
        begin
            if (vinSync[0])
                vinLow <= 1'b0;
            else if (vinSync[1])
                vinLow <= 1'b1;
            if (vinSync[0])
                powerSeen <= 1'b1;
        end
    end

    // Shared clock pin is open drain; it only ever drives low
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shareClkOut <= 1'b0;
            shareClkOe <= 1'b1;
        end
        else
        begin
            shareClkOut <= 1'b0;
            shareClkOe <= phaseRange[spfc_pkg::BIT_SHARE_CLK] ? vinLow // see [RULE6]
                                                              : !powerSeen; // see [RULE7]
        end
    end

    spfc_relock_timer #(
        .CYCLES(RELOCK_CYCLES)
    ) u_relock (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(freqStart),
        .busy(relockBusy)
    );

    // Unlock report while the PLL chases a new frequency, unless masked
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pllUnlock <= 1'b0;
        else
            pllUnlock <= relockBusy & !maskPllUnlock; // see [RULE11] [RULE12]
    end

    property p_noWriteRunning;
        (cmdStrobe & cmdWrite & running) |=> ($stable(phaseRange) & $stable(freqSelect));
    endproperty
    a_noWriteRunning: assert property (p_noWriteRunning) // see [RULE1]
        else $error("write taken while running");

    property p_busyOnReject;
        reject |=> busyFault;
    endproperty
    a_busyOnReject: assert property (p_busyOnReject) // see [RULE2]
        else $error("busy fault not raised");

    property p_phaseDecode;
        (phaseRange[2:0] == spfc_pkg::PH_90_270) |=> (phase0Deg == 9'd90 && phase1Deg == 9'd270);
    endproperty
    a_phaseDecode: assert property (p_phaseDecode) // see [RULE3]
        else $error("phase pair wrong");

    property p_range0;
        ##1 (voutMax0Mv == ($past(phaseRange[6]) ? 13'd2750 : 13'd4096));
    endproperty
    a_range0: assert property (p_range0) // see [RULE4]
        else $error("channel 0 range wrong");

    property p_range1;
        ##1 (voutMax1Mv == ($past(phaseRange[5]) ? 13'd2750 : 13'd5500));
    endproperty
    a_range1: assert property (p_range1) // see [RULE5]
        else $error("channel 1 range wrong");

    property p_shareLow;
        (phaseRange[4] & vinLow) |=> shareClkOe;
    endproperty
    a_shareLow: assert property (p_shareLow) // see [RULE6]
        else $error("shared clock released early");

    property p_shareFree;
        (!phaseRange[4] & powerSeen) |=> !shareClkOe;
    endproperty
    a_shareFree: assert property (p_shareFree) // see [RULE7]
        else $error("shared clock pulled after power-up");

    property p_freqDecode;
        (freqSelect == spfc_pkg::FSEL_1000) |=> (freqKhz == 10'd1000 && !extOscSel);
    endproperty
    a_freqDecode: assert property (p_freqDecode) // see [RULE8]
        else $error("frequency decode wrong");

    property p_unlockAfterChange;
        (freqStart & !maskPllUnlock) ##1 !maskPllUnlock |=> pllUnlock;
    endproperty
    a_unlockAfterChange: assert property (p_unlockAfterChange) // see [RULE11]
        else $error("no unlock report");

    property p_unlockMasked;
        maskPllUnlock |=> !pllUnlock;
    endproperty
    a_unlockMasked: assert property (p_unlockMasked) // see [RULE12]
        else $error("masked unlock reported");

    property p_readBack;
        (cmdStrobe & !cmdWrite & isPhase & lenOk) |=> (rdData[7:0] == $past(phaseRange)
            && rdByteCount == 2'h1);
    endproperty
    a_readBack: assert property (p_readBack) // see [RULE13] [RULE10]
        else $error("read back wrong");
endmodule : spfc_config
`default_nettype wire

// *** verilog/spfc_pkg.sv ***
/*
 * Constants for the switching phase and frequency configuration block:
 * command codes, reset values, field positions, frequency selector codes,
 * phase and range decodes and the relock timing.
 * Assumes a 10 MHz system clock and a PMBus front end outside the block.
 */
package spfc_pkg;
    // Command codes and data lengths
    localparam logic [7:0] CMD_PHASE_RANGE = 8'hf5;
    localparam logic [7:0] CMD_FREQ_SELECT = 8'h33;
    localparam logic [1:0] LEN_PHASE_RANGE = 2'h1;
    localparam logic [1:0] LEN_FREQ_SELECT = 2'h2;

    // Reset values of the two commands
    localparam logic [7:0] PHASE_RANGE_RESET = 8'h10;
    localparam logic [15:0] FREQ_SELECT_RESET = 16'hfabc;

    // Field positions inside the phase/range byte
    localparam int BIT_RANGE0 = 6;
    localparam int BIT_RANGE1 = 5;
    localparam int BIT_SHARE_CLK = 4;
    localparam int PHASE_MSB = 2;

    // Phase codes
    localparam logic [2:0] PH_0_180 = 3'h0;
    localparam logic [2:0] PH_90_270 = 3'h1;
    localparam logic [2:0] PH_0_240 = 3'h2;
    localparam logic [2:0] PH_0_120 = 3'h3;
    localparam logic [2:0] PH_120_240 = 3'h4;
    localparam logic [2:0] PH_60_240 = 3'h5;
    localparam logic [2:0] PH_120_300 = 3'h6;

    // Output range limits in millivolts
    localparam logic [12:0] VMAX_LOW_RANGE_MV = 13'h0abe;
    localparam logic [12:0] VMAX_CH0_MV = 13'h1000;
    localparam logic [12:0] VMAX_CH1_MV = 13'h157c;

    // Frequency selector codes, linear 5s/11s encoded
    localparam logic [15:0] FSEL_EXT = 16'h0000;
    localparam logic [15:0] FSEL_250 = 16'hf3e8;
    localparam logic [15:0] FSEL_350 = 16'hfabc;
    localparam logic [15:0] FSEL_425 = 16'hfb52;
    localparam logic [15:0] FSEL_500 = 16'hfbe8;
    localparam logic [15:0] FSEL_575 = 16'h023f;
    localparam logic [15:0] FSEL_650 = 16'h028a;
    localparam logic [15:0] FSEL_750 = 16'h02ee;
    localparam logic [15:0] FSEL_1000 = 16'h03e8;

    // Relock time of the switching PLL after a frequency change
    localparam int CLK_KHZ = 10000;
    localparam int PLL_RELOCK_US = 1000;
    localparam int PLL_RELOCK_CYCLES = (PLL_RELOCK_US * CLK_KHZ) / 1000;
endpackage : spfc_pkg

// *** verilog/spfc_relock_timer.sv ***
/*
 * Relock timer: after a start pulse it reports the PLL as unlocked for a
 * set number of system clock cycles.
 * Assumes start is a one-cycle pulse on clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module spfc_relock_timer #(
    parameter int CYCLES = spfc_pkg::PLL_RELOCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    output logic busy
);
    logic [31:0] count;

    // A new start restarts the wait, the PLL chases the latest frequency
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 32'h0;
            busy <= 1'b0;
        end
        else if (start)
        begin
            count <= 32'(CYCLES - 1);
            busy <= 1'b1;
        end
        else if (count != 32'h0)
            count <= count - 32'h1;
        else
            busy <= 1'b0;
    end
endmodule : spfc_relock_timer
`default_nettype wire
